// [shared/gci_cfg.svh]
// Constants of the GPIO control command interpreter.
`ifndef GCI_CFG_SVH
`define GCI_CFG_SVH

// -----------------------------------------------------------------------------
// Command type codes
// -----------------------------------------------------------------------------
`define GCI_CMD_GET_FUNC   8'h10
`define GCI_CMD_GET_DIR    8'h11
`define GCI_CMD_GET_LEVEL  8'h12
`define GCI_CMD_GET_STATE  8'h13
`define GCI_CMD_SET_DIR    8'h19
`define GCI_CMD_SET_LEVEL  8'h1A
`define GCI_CMD_SET_STATE  8'h1B

// -----------------------------------------------------------------------------
// Frame layout
// -----------------------------------------------------------------------------
`define GCI_ERR_BYTE       8'hFF
`define GCI_CMD_LAST_IDX   4'h8
`define GCI_P1_LAST_IDX    4'h4
`define GCI_RESP_LEN       4'h5
`define GCI_ERR_LEN        4'h1
`define GCI_VEC_WIDTH      32
`define GCI_DEF_PINS       11

`endif

// [shared/gci_pkg.sv]
// Types of the GPIO control command interpreter.
package gci_pkg;

  // ---------------------------------------------------------------------------
  // Interpreter states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    GCI_LOAD,
    GCI_RECV,
    GCI_EXEC,
    GCI_SEND,
    GCI_DRAIN
  } gci_state_type;

  typedef logic [31:0] gci_vec_type;

  // ---------------------------------------------------------------------------
  // All state of the interpreter
  // ---------------------------------------------------------------------------
  typedef struct packed {
    gci_state_type st;
    logic [3:0]    cnt;
    logic [7:0]    cmd;
    gci_vec_type   p1;
    gci_vec_type   p2;
    logic [39:0]   resp;
    logic [3:0]    rlen;
    logic          tail;
    gci_vec_type   dir;
    gci_vec_type   lvl;
    gci_vec_type   act;
  } gci_regs_type;

endpackage : gci_pkg

// [shared/gci_pin_if.sv]
// Carrier between the interpreter and its pin drivers.
`timescale 1ns/100ps
`default_nettype none

interface gci_pin_if #(parameter int PINS = 11);
  logic [PINS-1:0] dir;
  logic [PINS-1:0] lvl;
  logic [PINS-1:0] state;
  logic [PINS-1:0] active;

  modport ctrl (output dir, output lvl, output state, input active);
  modport drv  (input dir, input lvl, input state, output active);
endinterface : gci_pin_if

`default_nettype wire

// [logic/gci_pins.sv]
// Per-pin level translation between logical state and pin level.
`timescale 1ns/100ps
`default_nettype none

module gci_pins #(
  parameter int PINS = 11
) (
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  gci_pin_if.drv               pins,
  input  wire logic [PINS-1:0] pin_in_i,
  output logic      [PINS-1:0] pin_out_o,
  output logic      [PINS-1:0] pin_oe_o
);

  // ---------------------------------------------------------------------------
  // Registered drive, combinational input translation
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_out_o[g] <= 1'b0;
          pin_oe_o[g]  <= 1'b0;
        end else begin
          pin_out_o[g] <= pins.state[g] ^ pins.lvl[g];
          pin_oe_o[g]  <= pins.dir[g];
        end
      end
      assign pins.active[g] = pin_in_i[g] ^ pins.lvl[g];
    end
  endgenerate

endmodule : gci_pins

`default_nettype wire

// [logic/gci_top.sv]
// GPIO control command interpreter: nine-byte commands in, five-byte answers or one-byte error answers out.
//
// How it works
// - A command is one type byte followed by two four-byte parameters.
// - Each parameter is a 32-bit pin vector, one bit per pin.
// - Parameters arrive little endian; pin zero is bit 0 of the first byte.
// - Non-GPIO pins read as zero and are ignored by writes.
// - Every valid command is answered with exactly five bytes.
// - The answer echoes the command byte, then the current or updated vector.
// - An unknown command type is answered with one 0FFh byte only.
// - Commands are accepted from both stream and datagram transports.
// - Type codes 10h-13h read, 19h-1Bh write directions, levels, states.
// - Parameters a command does not use are ignored.
// - No command writes pin functions; functions come from configuration only.
// - Written values live in volatile flip-flops and revert at reset.
// - In the function answer one means user GPIO, zero dedicated.
// - Eleven controllable pins sit inside the 32-bit vector.
// - Pins default to GPIO inputs, active low, via the boot configuration.
// - Boot directions and active levels are loaded from configuration inputs.
// - A disable input stops all command servicing.
// - Writes update only pins whose first-parameter mask bit is one.
// - Direction one means output, zero input.
// - Level one means active low; state one means active.
`timescale 1ns/100ps
`default_nettype none
`include "gci_cfg.svh"

module gci_top #(
  parameter int PINS = `GCI_DEF_PINS
) (
  input  wire logic                 mclk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 rx_valid_i,
  input  wire logic [7:0]           rx_data_i,
  input  wire logic                 rx_last_i,
  input  wire logic                 rx_udp_i,
  output logic                      rx_ready_o,
  output logic                      tx_valid_o,
  output logic      [7:0]           tx_data_o,
  output logic                      tx_last_o,
  input  wire logic                 tx_ready_i,
  input  wire logic                 gpio_disable_i,
  input  wire gci_pkg::gci_vec_type cfg_func_i,
  input  wire gci_pkg::gci_vec_type boot_dir_i,
  input  wire gci_pkg::gci_vec_type boot_level_i,
  input  wire logic [PINS-1:0]      pin_in_i,
  output logic      [PINS-1:0]      pin_out_o,
  output logic      [PINS-1:0]      pin_oe_o
);
  import gci_pkg::*;

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  localparam gci_vec_type IMPL = ~(32'hFFFFFFFF << PINS);

  gci_regs_type r_reg;
  gci_regs_type r_next;
  gci_vec_type  in_act;
  gci_vec_type  gpio_m;
  gci_vec_type  wmask;
  gci_vec_type  state_rd;

  gci_pin_if #(.PINS(PINS)) pin_bus ();

  assign pin_bus.dir   = r_reg.dir[PINS-1:0];
  assign pin_bus.lvl   = r_reg.lvl[PINS-1:0];
  assign pin_bus.state = r_reg.act[PINS-1:0];
  assign in_act        = 32'(pin_bus.active);

  gci_pins #(.PINS(PINS)) u_pins (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n),
    .pins      (pin_bus),
    .pin_in_i  (pin_in_i),
    .pin_out_o (pin_out_o),
    .pin_oe_o  (pin_oe_o)
  );

  // ---------------------------------------------------------------------------
  // Derived vectors
  // ---------------------------------------------------------------------------
  assign gpio_m   = cfg_func_i & IMPL;
  assign wmask    = r_reg.p1 & gpio_m;
  assign state_rd = ((r_reg.dir & r_reg.act) | (~r_reg.dir & in_act)) & gpio_m;

  // ---------------------------------------------------------------------------
  // Handshake outputs
  // ---------------------------------------------------------------------------
  assign rx_ready_o = (r_reg.st == GCI_RECV) || (r_reg.st == GCI_DRAIN);
  assign tx_valid_o = (r_reg.st == GCI_SEND);
  assign tx_data_o  = r_reg.resp[7:0];
  assign tx_last_o  = (r_reg.st == GCI_SEND) && (r_reg.cnt == r_reg.rlen - 4'h1);

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    case (r_reg.st)
      GCI_LOAD: begin
        r_next.dir = boot_dir_i & IMPL;
        r_next.lvl = boot_level_i & IMPL;
        r_next.act = 32'h00000000;
        r_next.st  = GCI_RECV;
      end
      GCI_RECV: begin
        if (rx_valid_i) begin
          if (gpio_disable_i) begin
            r_next.cnt = 4'h0;
          end else begin
            if (r_reg.cnt == 4'h0) begin
              r_next.cmd = rx_data_i;
            end else if (r_reg.cnt <= `GCI_P1_LAST_IDX) begin
              r_next.p1 = {rx_data_i, r_reg.p1[31:8]};
            end else begin
              r_next.p2 = {rx_data_i, r_reg.p2[31:8]};
            end
            r_next.cnt = r_reg.cnt + 4'h1;
            if (r_reg.cnt == `GCI_CMD_LAST_IDX) begin
              r_next.st   = GCI_EXEC;
              r_next.cnt  = 4'h0;
              r_next.tail = rx_udp_i && !rx_last_i;
            end else if (rx_udp_i && rx_last_i) begin
              r_next.cnt = 4'h0;
            end
          end
        end
      end
      GCI_EXEC: begin
        r_next.rlen = `GCI_RESP_LEN;
        r_next.st   = GCI_SEND;
        r_next.cnt  = 4'h0;
        case (r_reg.cmd)
          `GCI_CMD_GET_FUNC: begin
            r_next.resp = {gpio_m, r_reg.cmd};
          end
          `GCI_CMD_GET_DIR: begin
            r_next.resp = {r_reg.dir & gpio_m, r_reg.cmd};
          end
          `GCI_CMD_GET_LEVEL: begin
            r_next.resp = {r_reg.lvl & gpio_m, r_reg.cmd};
          end
          `GCI_CMD_GET_STATE: begin
            r_next.resp = {state_rd, r_reg.cmd};
          end
          `GCI_CMD_SET_DIR: begin
            r_next.dir  = (r_reg.dir & ~wmask) | (r_reg.p2 & wmask);
            r_next.resp = {r_next.dir & gpio_m, r_reg.cmd};
          end
          `GCI_CMD_SET_LEVEL: begin
            r_next.lvl  = (r_reg.lvl & ~wmask) | (r_reg.p2 & wmask);
            r_next.resp = {r_next.lvl & gpio_m, r_reg.cmd};
          end
          `GCI_CMD_SET_STATE: begin
            r_next.act  = (r_reg.act & ~wmask) | (r_reg.p2 & wmask);
            r_next.resp = {((r_reg.dir & r_next.act) | (~r_reg.dir & in_act)) & gpio_m, r_reg.cmd};
          end
          default: begin
            r_next.resp = {32'h00000000, `GCI_ERR_BYTE};
            r_next.rlen = `GCI_ERR_LEN;
          end
        endcase
      end
      GCI_SEND: begin
        if (tx_ready_i) begin
          r_next.resp = {8'h00, r_reg.resp[39:8]};
          r_next.cnt  = r_reg.cnt + 4'h1;
          if (tx_last_o) begin
            r_next.cnt = 4'h0;
            r_next.st  = r_reg.tail ? GCI_DRAIN : GCI_RECV;
          end
        end
      end
      GCI_DRAIN: begin
        if (rx_valid_i && rx_last_i) begin
          r_next.tail = 1'b0;
          r_next.st   = GCI_RECV;
        end
      end
      default: begin
        r_next.st = GCI_RECV;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{st: GCI_LOAD, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [3:0] sent_cnt;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sent_cnt <= 4'h0;
    end else if (r_reg.st == GCI_EXEC) begin
      sent_cnt <= 4'h0;
    end else if (tx_valid_o && tx_ready_i) begin
      sent_cnt <= sent_cnt + 4'h1;
    end
  end

  chk_nine_bytes: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_RECV) ##1 (r_reg.st == GCI_EXEC) |->
      $past(r_reg.cnt) == `GCI_CMD_LAST_IDX && $past(rx_valid_i))
    else $error("Command executed without nine bytes.");

  chk_resp_five: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (tx_valid_o && tx_ready_i && tx_last_o && r_reg.resp[7:0] != `GCI_ERR_BYTE) |->
      sent_cnt == 4'h4 || r_reg.rlen == `GCI_ERR_LEN)
    else $error("Valid answer was not five bytes.");

  chk_echo_cmd: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_SEND && r_reg.cnt == 4'h0 && r_reg.rlen == `GCI_RESP_LEN) |->
      tx_data_o == r_reg.cmd)
    else $error("Answer did not start with the command byte.");

  chk_err_byte: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_EXEC && (r_reg.cmd < `GCI_CMD_GET_FUNC || r_reg.cmd > `GCI_CMD_SET_STATE ||
      (r_reg.cmd > `GCI_CMD_GET_STATE && r_reg.cmd < `GCI_CMD_SET_DIR))) |=>
      tx_valid_o && tx_last_o && tx_data_o == `GCI_ERR_BYTE)
    else $error("Unknown command not answered with a single error byte.");

  chk_mask_dir: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_EXEC && r_reg.cmd == `GCI_CMD_SET_DIR) |=>
      r_reg.dir == (($past(r_reg.dir) & ~$past(wmask)) | ($past(r_reg.p2) & $past(wmask))))
    else $error("Direction write ignored the mask.");

  chk_mask_level: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_EXEC && r_reg.cmd == `GCI_CMD_SET_LEVEL) |=>
      r_reg.lvl == (($past(r_reg.lvl) & ~$past(wmask)) | ($past(r_reg.p2) & $past(wmask))))
    else $error("Level write ignored the mask.");

  chk_mask_state: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_EXEC && r_reg.cmd == `GCI_CMD_SET_STATE) |=>
      r_reg.act == (($past(r_reg.act) & ~$past(wmask)) | ($past(r_reg.p2) & $past(wmask))))
    else $error("State write ignored the mask.");

  chk_pin_drive: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    pin_out_o == $past(r_reg.act[PINS-1:0] ^ r_reg.lvl[PINS-1:0]) &&
      pin_oe_o == $past(r_reg.dir[PINS-1:0]))
    else $error("Pin drive does not follow state, level and direction.");

  chk_non_gpio: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_EXEC && r_reg.cmd[4:3] == 2'h3) |=>
      (((r_reg.dir ^ $past(r_reg.dir)) | (r_reg.lvl ^ $past(r_reg.lvl)) |
       (r_reg.act ^ $past(r_reg.act))) & ~$past(gpio_m)) == 32'h00000000)
    else $error("Write changed a pin that is not GPIO.");

  chk_disabled_idle: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_RECV && gpio_disable_i) |=> r_reg.st != GCI_EXEC)
    else $error("Command serviced while disabled.");

  chk_func_answer: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_EXEC && r_reg.cmd == `GCI_CMD_GET_FUNC) |=>
      r_reg.resp[39:8] == $past(gpio_m) && r_reg.dir == $past(r_reg.dir))
    else $error("Function answer wrong or pin settings disturbed.");

  chk_boot_load: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_LOAD) |=> r_reg.dir == ($past(boot_dir_i) & IMPL) &&
      r_reg.lvl == ($past(boot_level_i) & IMPL) && r_reg.act == 32'h00000000)
    else $error("Boot configuration not loaded.");

  chk_short_udp: assert property (
    @(posedge mclk_i) disable iff (!rst_n)
    (r_reg.st == GCI_RECV && rx_valid_i && rx_udp_i && rx_last_i && !gpio_disable_i &&
      r_reg.cnt != `GCI_CMD_LAST_IDX) |=> r_reg.st == GCI_RECV && r_reg.cnt == 4'h0)
    else $error("Short datagram was not discarded.");

endmodule : gci_top

`default_nettype wire

// [logic/gci_pins_unused_never.sv]
// Spare source slot; it holds no logic.

// [verification/gci_host_model.sv]
// Host-side model that sends command bytes and collects answer bytes.
`timescale 1ns/100ps
`default_nettype none

module gci_host_model (
  input  wire logic       mclk_i,
  input  wire logic       rx_ready_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_last_o,
  output logic            rx_udp_o,
  output logic            tx_ready_o
);
  logic [7:0] resp [0:7];
  int         resp_n;

  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    rx_last_o  = 1'b0;
    rx_udp_o   = 1'b0;
    tx_ready_o = 1'b0;
    resp_n     = 0;
  end

  // ---------------------------------------------------------------------------
  // Command sender, one byte per accepted handshake
  // ---------------------------------------------------------------------------
  task automatic send(input logic [7:0] b [0:11], input int n, input logic udp);
    int w;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk_i);
      rx_valid_o = 1'b1;
      rx_data_o  = b[i];
      rx_udp_o   = udp;
      rx_last_o  = udp && (i == n - 1);
      w = 0;
      while (rx_ready_i !== 1'b1 && w < 200) begin
        @(negedge mclk_i);
        w++;
      end
      @(posedge mclk_i);
    end
    @(negedge mclk_i);
    rx_valid_o = 1'b0;
    rx_last_o  = 1'b0;
    rx_data_o  = ~rx_data_o;
  endtask : send

  // ---------------------------------------------------------------------------
  // Answer collector; stall holds ready low on that many of every three cycles
  // ---------------------------------------------------------------------------
  task automatic recv(input int stall, input int maxw);
    int   w;
    int   c;
    logic done;
    resp_n = 0;
    w      = 0;
    c      = 0;
    done   = 1'b0;
    while (!done && w < maxw) begin
      @(negedge mclk_i);
      tx_ready_o = ((c % 3) >= stall);
      c++;
      w++;
      if (tx_valid_i === 1'b1 && tx_ready_o && resp_n < 8) begin
        resp[resp_n] = tx_data_i;
        resp_n++;
        w    = 0;
        done = (tx_last_i === 1'b1);
      end
    end
    @(negedge mclk_i);
    tx_ready_o = 1'b0;
  endtask : recv
endmodule : gci_host_model

`default_nettype wire

// [verification/gci_top_bench.sv]
// Self-checking testbench of the GPIO control command interpreter.
`timescale 1ns/100ps
`default_nettype none
`include "gci_cfg.svh"

module gci_top_bench;
  import gci_pkg::*;

  localparam gci_vec_type CFG  = 32'h0000_07FB;
  localparam gci_vec_type GM   = 32'h0000_07FB;
  localparam gci_vec_type BLVL = 32'hFFFF_FFFF;

  logic        mclk_i;
  logic        reset_n_i;
  logic        gpio_disable;
  gci_vec_type boot_dir;
  logic [10:0] pin_in;
  logic [10:0] pin_out;
  logic [10:0] pin_oe;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_last;
  logic        rx_udp;
  logic        rx_ready;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_last;
  logic        tx_ready;
  gci_vec_type e_dir;
  gci_vec_type e_lvl;
  gci_vec_type e_act;
  int          n_errors;
  int          cmp_count;
  int          cyc;
  logic [7:0]  bad [0:4] = '{8'h14, 8'h18, 8'h1C, 8'h00, 8'hFF};

  gci_top #(.PINS(11)) uut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_last_i(rx_last), .rx_udp_i(rx_udp), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .tx_last_o(tx_last), .tx_ready_i(tx_ready), .gpio_disable_i(gpio_disable),
    .cfg_func_i(CFG), .boot_dir_i(boot_dir), .boot_level_i(BLVL), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe)
  );

  gci_host_model host (
    .mclk_i(mclk_i), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_last_i(tx_last), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_last_o(rx_last),
    .rx_udp_o(rx_udp), .tx_ready_o(tx_ready)
  );

  always #20 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic gci_vec_type upd(gci_vec_type old, gci_vec_type m, gci_vec_type v);
    return (old & ~(m & CFG)) | (v & m & CFG);
  endfunction : upd

  function automatic gci_vec_type st_rd();
    return GM & ((e_dir & e_act) | (~e_dir & ({21'h0, pin_in} ^ e_lvl)));
  endfunction : st_rd

  task automatic cmd(input logic [7:0] c, input gci_vec_type p1, input gci_vec_type p2, input logic udp,
                     input int n, input int stall, input int exp_n, input gci_vec_type exp_v);
    logic [7:0] b [0:11];
    b[0] = c;
    for (int i = 0; i < 4; i++) begin
      b[1 + i] = p1[8 * i +: 8];
      b[5 + i] = p2[8 * i +: 8];
    end
    for (int i = 9; i < 12; i++) begin
      b[i] = 8'hA5;
    end
    fork
      host.send(b, n, udp);
      host.recv(stall, 30);
    join
    chk("resp_len", exp_n, host.resp_n);
    if (exp_n == 5) begin
      chk("resp_cmd", {24'h0, c}, {24'h0, host.resp[0]});
      chk("resp_vec", exp_v, {host.resp[4], host.resp[3], host.resp[2], host.resp[1]});
    end
    if (exp_n == 1) begin
      chk("resp_err", {24'h0, `GCI_ERR_BYTE}, {24'h0, host.resp[0]});
    end
    chk("pin_oe", e_dir & 32'h7FF, {21'h0, pin_oe});
    chk("pin_out", (e_act ^ e_lvl) & 32'h7FF, {21'h0, pin_out});
  endtask : cmd

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    mclk_i       = 1'b0;
    reset_n_i    = 1'b0;
    gpio_disable = 1'b0;
    boot_dir     = 32'h0000_0000;
    pin_in       = 11'h5A3;
    n_errors     = 0;
    cmp_count    = 0;
    cyc          = 0;
    e_dir        = boot_dir;
    e_lvl        = BLVL;
    e_act        = 32'h0;
    repeat (2) @(negedge mclk_i);
    reset_n_i = 1'b1;
    cmd(`GCI_CMD_GET_FUNC, 32'hDEAD_BEEF, 32'h1234_5678, 1'b0, 9, 0, 5, GM);
    cmd(`GCI_CMD_GET_DIR, 32'h0, 32'h0, 1'b1, 9, 1, 5, e_dir & GM);
    cmd(`GCI_CMD_GET_LEVEL, 32'h0, 32'h0, 1'b0, 9, 0, 5, e_lvl & GM);
    e_dir = upd(e_dir, 32'hFFFF_0F0F, 32'h0000_0F35);
    cmd(`GCI_CMD_SET_DIR, 32'hFFFF_0F0F, 32'h0000_0F35, 1'b0, 9, 2, 5, e_dir & GM);
    e_lvl = upd(e_lvl, 32'h0000_00FF, 32'h0000_00A5);
    cmd(`GCI_CMD_SET_LEVEL, 32'h0000_00FF, 32'h0000_00A5, 1'b1, 9, 0, 5, e_lvl & GM);
    e_act = upd(e_act, 32'h0000_07FF, 32'h0000_0456);
    cmd(`GCI_CMD_SET_STATE, 32'h0000_07FF, 32'h0000_0456, 1'b0, 9, 1, 5, st_rd());
    cmd(`GCI_CMD_GET_STATE, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0, 9, 0, 5, st_rd());
    cmd(`GCI_CMD_GET_DIR, 32'h0, 32'h0, 1'b1, 12, 0, 5, e_dir & GM);
    cmd(`GCI_CMD_SET_DIR, 32'hFFFF_FFFF, 32'h0, 1'b1, 5, 0, 0, 32'h0);
    foreach (bad[i]) begin
      cmd(bad[i], 32'hFFFF_FFFF, 32'h0, 1'b0, 9, 0, 1, 32'h0);
    end
    cmd(`GCI_CMD_GET_FUNC, 32'h0, 32'h0, 1'b0, 9, 0, 5, GM);
    gpio_disable = 1'b1;
    cmd(`GCI_CMD_SET_DIR, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0, 9, 0, 0, 32'h0);
    gpio_disable = 1'b0;
    cmd(`GCI_CMD_GET_DIR, 32'h0, 32'h0, 1'b0, 9, 0, 5, e_dir & GM);
    boot_dir  = 32'h0000_0300;
    reset_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    reset_n_i = 1'b1;
    e_dir     = boot_dir;
    e_lvl     = BLVL;
    e_act     = 32'h0;
    cmd(`GCI_CMD_GET_DIR, 32'h0, 32'h0, 1'b0, 9, 0, 5, e_dir & GM);
    cmd(`GCI_CMD_GET_STATE, 32'h0, 32'h0, 1'b1, 9, 0, 5, st_rd());
    end_sim();
  end
endmodule : gci_top_bench

`default_nettype wire
